//--- core/tcal_pkg.sv
// Shared constants for the thermometer core and its bus master.
package tcal_pkg;
   // Command codes.
   localparam logic [7:0] CMD_CONVERT = 8'h44;
   localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;
   localparam logic [7:0] CMD_WRITE_PAD = 8'h4E;
   localparam logic [7:0] CMD_READ_PAD = 8'hBE;
   // Reset values and field layout.
   localparam logic [15:0] TEMP_RESET = 16'h0550;
   localparam logic [15:0] TEMP_FULL_MASK = 16'hFFFF;
   localparam logic [1:0] RES_12BIT = 2'h3;
   localparam logic [7:0] UPPER_DEFAULT = 8'h7F;
   localparam logic [7:0] LOWER_DEFAULT = 8'h80;
   localparam logic CFG_RSVD_HIGH = 1'h0;
   localparam logic [4:0] CFG_RSVD_LOW = 5'h1F;
   localparam int CFG_RES_LSB = 5;
   localparam int CFG_RES_MSB = 6;
   localparam int CMP_MSB = 11;
   localparam int CMP_LSB = 4;
   // Frame sizes in bits.
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] WR_BITS = 6'h18;
   localparam logic [5:0] PAD_BITS = 6'h28;
   // Slot timing in clock cycles.
   localparam logic [5:0] SLOT_LEN = 6'h10;
   localparam logic [5:0] LOW1_LEN = 6'h02;
   localparam logic [5:0] LOW0_LEN = 6'h08;
   localparam logic [5:0] LOW0_MIN = 6'h05;
   localparam logic [5:0] RESET_LEN = 6'h20;
   localparam logic [5:0] RESET_MIN = 6'h18;
   localparam logic [5:0] RESET_GAP = 6'h08;
   localparam logic [5:0] SAMPLE_AT = 6'h05;
   localparam logic [5:0] HOLD_LEN = 6'h08;
   localparam logic [5:0] LOWC_MAX = 6'h3F;
   // Conversion time at full resolution.
   localparam int CNT_W = 28;
   localparam int CONV12_MS = 750;
   localparam int CLK_KHZ = 200000;
   localparam int CONV12_CYCLES = CONV12_MS * CLK_KHZ;
endpackage

//--- core/tcal_link_if.sv
// Open-drain data line shared by the thermometer core and the bus master.
`timescale 1ns/1ps
interface tcal_link_if;
   logic mst_pull;
   logic dev_pull;
   logic mst_strong;
   logic dq;
   // Either party pulling low wins; otherwise the pullup holds the line high.
   assign dq = ~(mst_pull | dev_pull);
   modport mst (input dq, output mst_pull, output mst_strong);
   modport dev (input dq, output dev_pull, input mst_strong);
endinterface

//--- core/tcal_device.sv
// Thermometer core: command decode, conversion, result register and alarm flag.
`timescale 1ns/1ps
module tcal_device #(
   parameter int CONV_CYCLES = tcal_pkg::CONV12_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Link
   tcal_link_if.dev bus,
   // Sensor side
   input wire logic [15:0] temp_sample,
   output logic [15:0] temp_value,
   output logic conv_busy,
   output logic alarm_flag
);
   typedef enum logic [2:0] {D_IDLE, D_CMD, D_WRPAD, D_TX, D_POLL} tcal_dstate_e;

   typedef struct packed {
      tcal_dstate_e state;
      logic [7:0] upper;
      logic [7:0] lower;
      logic [1:0] res;
      logic [15:0] temp;
      logic alarm;
      logic busy;
      logic [tcal_pkg::CNT_W-1:0] conv_cnt;
      logic dq_prev;
      logic [5:0] lowc;
      logic [5:0] hold;
      logic [39:0] sh;
      logic [5:0] nbits;
   } tcal_dev_s;

   tcal_dev_s s_r;
   tcal_dev_s s_nxt;

   logic rise;
   logic fall;
   logic bit_in;
   logic [15:0] res_mask;
   logic [15:0] new_temp;
   logic [7:0] cfg_byte;
   logic [tcal_pkg::CNT_W-1:0] conv_len;

   assign rise = bus.dq & ~s_r.dq_prev;
   assign fall = ~bus.dq & s_r.dq_prev;
   assign bit_in = s_r.lowc < tcal_pkg::LOW0_MIN;
   assign res_mask = tcal_pkg::TEMP_FULL_MASK << (tcal_pkg::RES_12BIT - s_r.res);
   assign new_temp = temp_sample & res_mask;
   assign cfg_byte = {tcal_pkg::CFG_RSVD_HIGH, s_r.res, tcal_pkg::CFG_RSVD_LOW};
   assign conv_len = tcal_pkg::CNT_W'(CONV_CYCLES) >> (tcal_pkg::RES_12BIT - s_r.res);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.dq_prev = bus.dq;
      if (bus.dq)
      begin
         s_nxt.lowc = '0;
      end
      else if (s_r.lowc != tcal_pkg::LOWC_MAX)
      begin
         s_nxt.lowc = s_r.lowc + 6'h01;
      end
      if (s_r.hold != '0)
      begin
         s_nxt.hold = s_r.hold - 6'h01;
      end
      if (s_r.busy)
      begin
         if (s_r.conv_cnt == '0)
         begin
            s_nxt.busy = 1'b0;
            s_nxt.temp = new_temp;
            s_nxt.alarm = ($signed(new_temp[tcal_pkg::CMP_MSB:tcal_pkg::CMP_LSB])
                           <= $signed(s_r.lower))
                        | ($signed(new_temp[tcal_pkg::CMP_MSB:tcal_pkg::CMP_LSB])
                           >= $signed(s_r.upper));
         end
         else
         begin
            s_nxt.conv_cnt = s_r.conv_cnt - 1'b1;
         end
      end
      // A long low from any state starts a new frame; the device's own holds stay short.
      if (rise && s_r.lowc >= tcal_pkg::RESET_MIN)
      begin
         s_nxt.state = D_CMD;
         s_nxt.nbits = tcal_pkg::CMD_BITS;
      end
      else
      begin
         case (s_r.state)
            D_CMD, D_WRPAD:
            begin
               if (rise)
               begin
                  s_nxt.sh = {bit_in, s_r.sh[39:1]};
                  s_nxt.nbits = s_r.nbits - 6'h01;
                  if (s_r.nbits == 6'h01 && s_r.state == D_WRPAD)
                  begin
                     // bytes 2 and 3 are limits
                     s_nxt.upper = s_nxt.sh[23:16];
                     s_nxt.lower = s_nxt.sh[31:24];
                     s_nxt.res = s_nxt.sh[32 + tcal_pkg::CFG_RES_MSB:32 + tcal_pkg::CFG_RES_LSB];
                     s_nxt.state = D_IDLE;
                  end
                  else if (s_r.nbits == 6'h01)
                  begin
                     case (s_nxt.sh[39:32])
                        tcal_pkg::CMD_CONVERT:
                        begin
                           if (!s_r.busy)
                           begin
                              s_nxt.busy = 1'b1;
                              s_nxt.conv_cnt = conv_len - 1'b1;
                           end
                           s_nxt.state = D_POLL;
                        end
                        tcal_pkg::CMD_ALARM_SEARCH:
                        begin
                           // only an alarming device pulls low
                           s_nxt.sh = {39'h0, ~s_r.alarm};
                           s_nxt.nbits = 6'h01;
                           s_nxt.state = D_TX;
                        end
                        tcal_pkg::CMD_READ_PAD:
                        begin
                           // bytes 0 and 1 are the result
                           s_nxt.sh = {cfg_byte, s_r.lower, s_r.upper, s_r.temp};
                           s_nxt.nbits = tcal_pkg::PAD_BITS;
                           s_nxt.state = D_TX;
                        end
                        tcal_pkg::CMD_WRITE_PAD:
                        begin
                           s_nxt.nbits = tcal_pkg::WR_BITS;
                           s_nxt.state = D_WRPAD;
                        end
                        default:
                        begin
                           s_nxt.state = D_IDLE;
                        end
                     endcase
                  end
               end
            end
            D_TX:
            begin
               if (fall)
               begin
                  if (!s_r.sh[0])
                  begin
                     s_nxt.hold = tcal_pkg::HOLD_LEN;
                  end
                  s_nxt.sh = {1'b0, s_r.sh[39:1]};
                  s_nxt.nbits = s_r.nbits - 6'h01;
                  if (s_r.nbits == 6'h01)
                  begin
                     s_nxt.state = D_IDLE;
                  end
               end
            end
            D_POLL:
            begin
               // busy answers 0, done answers 1
               if (fall && s_r.busy)
               begin
                  s_nxt.hold = tcal_pkg::HOLD_LEN;
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // limits and resolution reload at reset, standing in for the stored copy.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.state <= D_IDLE;
         s_r.res <= tcal_pkg::RES_12BIT;
         s_r.temp <= tcal_pkg::TEMP_RESET;
         s_r.upper <= tcal_pkg::UPPER_DEFAULT;
         s_r.lower <= tcal_pkg::LOWER_DEFAULT;
         s_r.dq_prev <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign bus.dev_pull = s_r.hold != '0;
   assign temp_value = s_r.temp;
   assign conv_busy = s_r.busy;
   assign alarm_flag = s_r.alarm;
endmodule

//--- core/tcal_master.sv
// Bus master: frames commands into slots, reads answers and powers conversions.
`timescale 1ns/1ps
module tcal_master #(
   parameter int CONV_WAIT = tcal_pkg::CONV12_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Link
   tcal_link_if.mst bus,
   // Command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [23:0] cmd_wdata,
   input wire logic parasite,
   output logic cmd_ready,
   // Answer port
   output logic rsp_valid,
   output logic [39:0] rsp_data
);
   typedef enum logic [2:0] {M_IDLE, M_RESET, M_GAP, M_SLOT, M_STRONG} tcal_mstate_e;

   typedef struct packed {
      tcal_mstate_e state;
      logic [7:0] cmd;
      logic [39:0] sh;
      logic [39:0] rd;
      logic [5:0] nbits;
      logic in_cmd;
      logic rd_mode;
      logic poll;
      logic [tcal_pkg::CNT_W-1:0] timer;
      logic rsp_valid;
      logic [39:0] rsp_data;
   } tcal_mst_s;

   tcal_mst_s s_r;
   tcal_mst_s s_nxt;
   logic [5:0] low_len;

   assign low_len = (s_r.rd_mode || s_r.sh[0]) ? tcal_pkg::LOW1_LEN : tcal_pkg::LOW0_LEN;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rsp_valid = 1'b0;
      case (s_r.state)
         M_IDLE:
         begin
            if (cmd_valid)
            begin
               s_nxt.cmd = cmd_code;
               s_nxt.sh = {8'h00, cmd_wdata, cmd_code};
               s_nxt.rd = '0;
               s_nxt.nbits = tcal_pkg::CMD_BITS;
               s_nxt.in_cmd = 1'b1;
               s_nxt.rd_mode = 1'b0;
               s_nxt.poll = 1'b0;
               s_nxt.timer = tcal_pkg::CNT_W'(tcal_pkg::RESET_LEN) - 1'b1;
               s_nxt.state = M_RESET;
            end
         end
         M_RESET, M_GAP:
         begin
            if (s_r.timer != '0)
            begin
               s_nxt.timer = s_r.timer - 1'b1;
            end
            else if (s_r.state == M_RESET)
            begin
               s_nxt.timer = tcal_pkg::CNT_W'(tcal_pkg::RESET_GAP) - 1'b1;
               s_nxt.state = M_GAP;
            end
            else
            begin
               s_nxt.state = M_SLOT;
            end
         end
         M_SLOT:
         begin
            s_nxt.timer = s_r.timer + 1'b1;
            if (s_r.rd_mode && s_r.timer == tcal_pkg::CNT_W'(tcal_pkg::SAMPLE_AT))
            begin
               s_nxt.rd = {bus.dq, s_r.rd[39:1]};
            end
            if (s_r.timer == tcal_pkg::CNT_W'(tcal_pkg::SLOT_LEN) - 1'b1)
            begin
               s_nxt.timer = '0;
               s_nxt.sh = {1'b0, s_r.sh[39:1]};
               s_nxt.nbits = s_r.nbits - 6'h01;
               if (s_r.poll)
               begin
                  // poll until the device answers 1
                  s_nxt.nbits = s_r.nbits;
                  if (s_r.rd[39])
                  begin
                     s_nxt.state = M_IDLE;
                     s_nxt.rsp_valid = 1'b1;
                     s_nxt.rsp_data = {39'h0, 1'b1};
                  end
               end
               else if (s_r.nbits == 6'h01 && s_r.in_cmd)
               begin
                  s_nxt.in_cmd = 1'b0;
                  case (s_r.cmd)
                     tcal_pkg::CMD_WRITE_PAD:
                     begin
                        s_nxt.nbits = tcal_pkg::WR_BITS;
                     end
                     tcal_pkg::CMD_READ_PAD:
                     begin
                        s_nxt.rd_mode = 1'b1;
                        s_nxt.nbits = tcal_pkg::PAD_BITS;
                     end
                     tcal_pkg::CMD_ALARM_SEARCH:
                     begin
                        s_nxt.rd_mode = 1'b1;
                        s_nxt.nbits = 6'h01;
                     end
                     tcal_pkg::CMD_CONVERT:
                     begin
                        // parasite device gets strong pullup, no polling
                        if (parasite)
                        begin
                           s_nxt.timer = tcal_pkg::CNT_W'(CONV_WAIT) - 1'b1;
                           s_nxt.state = M_STRONG;
                        end
                        else
                        begin
                           s_nxt.rd_mode = 1'b1;
                           s_nxt.poll = 1'b1;
                           s_nxt.nbits = 6'h01;
                        end
                     end
                     default:
                     begin
                        s_nxt.state = M_IDLE;
                        s_nxt.rsp_valid = 1'b1;
                        s_nxt.rsp_data = '0;
                     end
                  endcase
               end
               else if (s_r.nbits == 6'h01)
               begin
                  s_nxt.state = M_IDLE;
                  s_nxt.rsp_valid = 1'b1;
                  // a 0 means the device is alarming
                  s_nxt.rsp_data = (s_r.cmd == tcal_pkg::CMD_ALARM_SEARCH) ?
                                   {39'h0, s_nxt.rd[39]} : s_nxt.rd;
               end
            end
         end
         M_STRONG:
         begin
            // Nothing else may use the line while the pullup is on.
            if (s_r.timer != '0)
            begin
               s_nxt.timer = s_r.timer - 1'b1;
            end
            else
            begin
               s_nxt.state = M_IDLE;
               s_nxt.rsp_valid = 1'b1;
               s_nxt.rsp_data = {39'h0, 1'b1};
            end
         end
         default:
         begin
            s_nxt.state = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.state <= M_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // master only pulls low or releases
   assign bus.mst_pull = (s_r.state == M_RESET)
                       | (s_r.state == M_SLOT && s_r.timer < tcal_pkg::CNT_W'(low_len));
   assign bus.mst_strong = s_r.state == M_STRONG;
   assign cmd_ready = s_r.state == M_IDLE;
   assign rsp_valid = s_r.rsp_valid;
   assign rsp_data = s_r.rsp_data;
endmodule

//--- sim/tcal_props.sv
// Temporal checks on the open-drain link and the results of the thermometer core.
`timescale 1ns/1ps
module tcal_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Link
   input wire logic mst_pull,
   input wire logic dev_pull,
   input wire logic mst_strong,
   input wire logic dq,
   // Core results
   input wire logic [15:0] temp_value,
   input wire logic conv_busy,
   input wire logic alarm_flag
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_dev_answer;
      dev_pull [*8] ##1 !dev_pull;
   endsequence
   sequence s_master_fall;
      $past(mst_pull) || $past(mst_pull, 2);
   endsequence

   property p_wired_and;
      dq == !(mst_pull || dev_pull);
   endproperty
   property p_dev_hold;
      $rose(dev_pull) |-> s_dev_answer;
   endproperty
   property p_dev_after_master;
      $rose(dev_pull) |-> s_master_fall;
   endproperty
   property p_strong_quiet;
      mst_strong |-> !mst_pull && !dev_pull;
   endproperty
   property p_strong_span;
      $rose(mst_strong) |-> mst_strong [*8];
   endproperty
   property p_reset_state;
      $rose(resetn) |-> temp_value == 16'h0550 && !alarm_flag && !conv_busy;
   endproperty
   property p_temp_at_end;
      $changed(temp_value) |-> $fell(conv_busy);
   endproperty
   property p_alarm_at_end;
      $changed(alarm_flag) |-> $fell(conv_busy);
   endproperty
   property p_sign_copies;
      temp_value[15:11] == {5{temp_value[11]}};
   endproperty

   a_wired_and:
      assert property (p_wired_and) else $error("line level disagrees with pulls");
   a_dev_hold:
      assert property (p_dev_hold) else $error("device answer pulse has wrong length");
   a_dev_after_master:
      assert property (p_dev_after_master) else $error("device pulled without slot start");
   a_strong_quiet:
      assert property (p_strong_quiet) else $error("line pulled under strong pullup");
   a_strong_span:
      assert property (p_strong_span) else $error("strong pullup dropped early");
   a_reset_state:
      assert property (p_reset_state) else $error("core not idle at reset value");
   a_temp_at_end:
      assert property (p_temp_at_end) else $error("result changed outside conversion end");
   a_alarm_at_end:
      assert property (p_alarm_at_end) else $error("alarm changed outside conversion end");
   a_sign_copies:
      assert property (p_sign_copies) else $error("result sign bits disagree");
endmodule

//--- sim/temp_conversion_alarm_logic_tb.sv
// Self-checking bench joining the thermometer core and its bus master.
`timescale 1ns/1ps
module temp_conversion_alarm_logic_tb;
   typedef struct {logic [15:0] smp; logic [1:0] res; logic [7:0] up; logic [7:0] lo;
      logic [15:0] t; logic al;} tcal_row_s;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic [23:0] cmd_wdata = 24'h000000;
   logic parasite = 1'b0;
   logic [15:0] temp_sample = 16'h0000;
   logic cmd_ready, rsp_valid, conv_busy, alarm_flag, seen_busy, seen_strong;
   logic [39:0] rsp_data;
   logic [39:0] exp_pad;
   logic [15:0] temp_value;
   int fail_count = 0;
   int n_checks = 0;
   tcal_row_s rows [5];

   always #2.5 mclk = ~mclk;

   tcal_link_if link ();
   // Short conversions keep the run small; the 5000-cycle limit in run is a fixed count, well above 400.
   tcal_device #(.CONV_CYCLES(400)) u_tcal_device (.mclk(mclk), .resetn(resetn),
      .bus(link.dev), .temp_sample(temp_sample), .temp_value(temp_value),
      .conv_busy(conv_busy), .alarm_flag(alarm_flag));
   tcal_master #(.CONV_WAIT(400)) u_tcal_master (.mclk(mclk), .resetn(resetn),
      .bus(link.mst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .parasite(parasite), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data));
   tcal_props u_tcal_props (.mclk(mclk), .resetn(resetn), .mst_pull(link.mst_pull),
      .dev_pull(link.dev_pull), .mst_strong(link.mst_strong), .dq(link.dq),
      .temp_value(temp_value), .conv_busy(conv_busy), .alarm_flag(alarm_flag));

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Issues one command and waits for its answer pulse, seen at a falling edge.
   task automatic run(input logic [7:0] code, input logic [23:0] wd, input logic par);
      int n;
      n = 0;
      seen_busy = 1'b0;
      seen_strong = 1'b0;
      cmd_code = code;
      cmd_wdata = wd;
      parasite = par;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 5000)
      begin
         @(negedge mclk);
         seen_busy |= conv_busy;
         seen_strong |= link.mst_strong;
         n++;
      end
      if (n >= 5000)
      begin
         fail_count++;
         end_of_test();
      end
   endtask

   initial
   begin
      rows[0] = '{16'h0191, 2'h3, 8'h7F, 8'h80, 16'h0191, 1'b0};
      rows[1] = '{16'h0191, 2'h2, 8'h19, 8'h80, 16'h0190, 1'b1};
      rows[2] = '{16'hFE6F, 2'h1, 8'h7F, 8'hE6, 16'hFE6C, 1'b1};
      rows[3] = '{16'hFF5E, 2'h0, 8'h0A, 8'hF4, 16'hFF58, 1'b0};
      rows[4] = '{16'h07D0, 2'h3, 8'h7D, 8'h80, 16'h07D0, 1'b1};
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk);
      foreach (rows[i])
      begin
         temp_sample = rows[i].smp;
         run(tcal_pkg::CMD_WRITE_PAD, {1'b0, rows[i].res, 5'h1F, rows[i].lo, rows[i].up}, 1'b0);
         run(tcal_pkg::CMD_CONVERT, 24'h000000, 1'b0);
         chk(rsp_data[0], 1'b1); // Poll answer
         chk(seen_busy, 1'b1); // Conversion ran
         chk(temp_value, rows[i].t); // Result word
         chk(alarm_flag, rows[i].al); // Alarm flag
         run(tcal_pkg::CMD_READ_PAD, 24'h000000, 1'b0);
         exp_pad = {1'b0, rows[i].res, 5'h1F, rows[i].lo, rows[i].up, rows[i].t};
         chk(rsp_data, exp_pad); // Pad bytes
         run(tcal_pkg::CMD_ALARM_SEARCH, 24'h000000, 1'b0);
         chk(rsp_data[0], !rows[i].al); // Search answer
         $display("row %0d done", i);
      end
      // An unknown code must not start a conversion, and pad writes leave the result alone.
      temp_sample = 16'h0008;
      run(8'h00, 24'h000000, 1'b0);
      chk(seen_busy, 1'b0); // No conversion
      chk(rsp_data, 40'h0000000000); // Unknown code answer
      run(tcal_pkg::CMD_WRITE_PAD, 24'h7F807F, 1'b0);
      chk(temp_value, 16'h07D0); // Result read-only
      $display("unknown code test done");
      @(negedge mclk);
      resetn = 1'b0;
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk);
      chk(temp_value, 16'h0550); // Reset result
      chk(alarm_flag, 1'b0); // Reset alarm clear
      chk(cmd_ready, 1'b1); // Port idle
      run(tcal_pkg::CMD_READ_PAD, 24'h000000, 1'b0);
      chk(rsp_data, 40'h7F807F0550); // Reset pad
      $display("reset test done");
      // Parasite mode has no polling, so the result is checked a few cycles after the answer.
      temp_sample = 16'h0191;
      run(tcal_pkg::CMD_CONVERT, 24'h000000, 1'b1);
      repeat (4) @(negedge mclk);
      chk(seen_strong, 1'b1); // Strong pullup
      chk(rsp_data[0], 1'b1); // Pullup answer
      chk(temp_value, 16'h0191); // Full resolution
      $display("parasite test done");
      end_of_test();
   end
endmodule
